// [spc_port.sv]
// Serial command port with array, lock, config and control registers
// What this block does
// - Mode 0; clock idles low between transfers
// - Output bits launched on clock rising edges
// - Active only while chip select low
// - Eight-bit opcode first, everything MSB first
// - Input sampled on each rising clock edge
// - Static logic; clock may pause anytime
// - Opcodes setting and clearing write latch
// - Opcodes for array write, read, lock status
// - Config and control writes, status read opcodes
// - Partition lock opcode takes select byte
// - Nonvolatile writes refused while latch clear
// - Write after latch set same frame ignored
// - Sixteen-bit address, only low nine used
// - Page write wraps within sixteen-byte page
// - Write commits only on byte-boundary deselect
// - Lock status returns lock bits, rest zero
// - Lock status reads high while write busy
// - Read auto-increments, wraps 1FF to 000
// - Config write takes effect immediately
// - Control write updates volatile outputs immediately
// - Status read returns three status bits
// - Locked partitions block writes; eight settings
// - Latch clears at reset and when a write cycle starts
// - Deselect after lock byte starts nonvolatile write
`timescale 1ns/10ps
module spc_port #(
	parameter int unsigned NV_WRITE_CYCLES = spc_pkg::TWC_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_sck,
	input  wire logic        spi_si,
	output logic             spi_so,
	output logic             spi_so_oe_n,
	input  wire logic [2:0]  status_bits,
	output logic [15:0]      cfg_reg,
	output logic [15:0]      ctl_reg,
	output logic [2:0]       lock_select_bits,
	output logic             write_latch,
	output logic             write_busy
);
	wire spc_pkg::spc_pins_t pins;
	spc_pkg::spc_state_t state_q, state_d;

	logic [2:0]  bitcnt_q, bitcnt_d;
	logic        byteidx_q, byteidx_d;
	logic [7:0]  shreg_q, shreg_d;
	logic [7:0]  txsr_q, txsr_d;
	logic        so_q, so_d;
	logic        oe_n_q, oe_n_d;
	logic [8:0]  addr_q, addr_d;
	logic        is_wr_q, is_wr_d;
	logic        has_data_q, has_data_d;
	logic [7:0]  hold_q, hold_d;
	logic        wel_q, wel_d;
	logic        wel_pend_q, wel_pend_d;
	logic [2:0]  lock_q, lock_d;
	logic [15:0] cfg_q, cfg_d;
	logic [15:0] ctl_q, ctl_d;
	logic [23:0] busy_q, busy_d;
	logic [15:0] mask_q, mask_d;
	logic [4:0]  cpage_q, cpage_d;
	logic        flush_q, flush_d;
	logic [3:0]  fidx_q, fidx_d;
	logic        sck_d1_q, cs_d1_q;
	logic        buf_we;
	logic [7:0]  pbuf [spc_pkg::PAGE_BYTES];
	logic [7:0]  mem [spc_pkg::MEM_DEPTH];

	logic        sck_rise, cs_rise, byte_done, busy;
	logic [7:0]  sh_n, lock_byte, stat_byte, rd_byte;
	logic [8:0]  rd_addr;

	// Pins come from the host's domain
	spc_sync #(.RST_VAL(1'b1)) u_sync_cs (
		.mclk (mclk),
		.rstn (rstn),
		.d    (spi_cs_n),
		.q    (pins.cs_n)
	);
	spc_sync #(.RST_VAL(1'b0)) u_sync_sck (
		.mclk (mclk),
		.rstn (rstn),
		.d    (spi_sck),
		.q    (pins.sck)
	);
	spc_sync #(.RST_VAL(1'b0)) u_sync_si (
		.mclk (mclk),
		.rstn (rstn),
		.d    (spi_si),
		.q    (pins.si)
	);

	// Edge finders on the synchronised pins
	// any sck pause
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sck_d1_q <= 1'b0;
			cs_d1_q  <= 1'b1;
		end else begin
			sck_d1_q <= pins.sck;
			cs_d1_q  <= pins.cs_n;
		end
	end

	assign sck_rise  = pins.sck & ~sck_d1_q & ~pins.cs_n;
	assign cs_rise   = pins.cs_n & ~cs_d1_q;
	assign byte_done = (bitcnt_q == 3'h7);
	assign sh_n      = {shreg_q[6:0], pins.si};
	assign busy      = (busy_q != 24'h000000);
	assign lock_byte = {5'h00, lock_q};
	assign stat_byte = {5'h00, status_bits};
	assign rd_addr   = (state_q == spc_pkg::ST_ADDR) ?
		{addr_q[8], sh_n} : addr_q;
	assign rd_byte   = mem[rd_addr];

	function automatic logic page_locked(input logic [2:0] sel,
		input logic [4:0] page);
		case (sel)
			3'h1: page_locked = (page[4:3] == 2'h0);
			3'h2: page_locked = (page[4:3] == 2'h1);
			3'h3: page_locked = (page[4:3] == 2'h2);
			3'h4: page_locked = (page[4:3] == 2'h3);
			3'h5: page_locked = ~page[4];
			3'h6: page_locked = (page == 5'h00);
			3'h7: page_locked = (page == 5'h1f);
			default: page_locked = 1'b0;
		endcase
	endfunction

	// Frame decoder, shifters and register updates
	always_comb begin
		state_d    = state_q;
		bitcnt_d   = bitcnt_q;
		byteidx_d  = byteidx_q;
		shreg_d    = shreg_q;
		txsr_d     = txsr_q;
		so_d       = so_q;
		oe_n_d     = pins.cs_n;
		addr_d     = addr_q;
		is_wr_d    = is_wr_q;
		has_data_d = has_data_q;
		hold_d     = hold_q;
		wel_d      = wel_q;
		wel_pend_d = wel_pend_q;
		lock_d     = lock_q;
		cfg_d      = cfg_q;
		ctl_d      = ctl_q;
		busy_d     = busy ? busy_q - 24'h000001 : busy_q;
		mask_d     = mask_q;
		cpage_d    = cpage_q;
		flush_d    = flush_q;
		fidx_d     = fidx_q;
		buf_we     = 1'b0;
		// Flush the page buffer into the array during the busy time
		if (flush_q) begin
			fidx_d = fidx_q + 4'h1;
			if (fidx_q == 4'hf) begin
				flush_d = 1'b0;
			end
		end
		if (pins.cs_n) begin
			state_d    = spc_pkg::ST_OPCODE;
			bitcnt_d   = 3'h0;
			byteidx_d  = 1'b0;
			has_data_d = 1'b0;
			so_d       = 1'b0;
			if (cs_rise) begin
				// latch set only at frame end
				if (wel_pend_q) begin
					wel_d = 1'b1;
				end
				wel_pend_d = 1'b0;
				if (state_q == spc_pkg::ST_WDATA && bitcnt_q == 3'h0 &&
					has_data_q && !page_locked(lock_q, addr_q[8:4])) begin
					busy_d  = NV_WRITE_CYCLES[23:0];
					cpage_d = addr_q[8:4];
					flush_d = 1'b1;
					fidx_d  = 4'h0;
					wel_d   = 1'b0;
				end
				if (state_q == spc_pkg::ST_LOCK && bitcnt_q == 3'h0 &&
					has_data_q) begin
					lock_d = hold_q[2:0];
					busy_d = NV_WRITE_CYCLES[23:0];
					wel_d  = 1'b0;
				end
			end
		end else if (sck_rise) begin
			shreg_d  = sh_n;
			bitcnt_d = bitcnt_q + 3'h1;
			so_d     = txsr_q[7];
			txsr_d   = {txsr_q[6:0], 1'b0};
			case (state_q)
				spc_pkg::ST_OPCODE: begin
					if (byte_done) begin
						state_d = spc_pkg::ST_IGNORE;
						case (sh_n)
							spc_pkg::OP_SET_WRITE_LATCH: begin
								wel_pend_d = 1'b1;
							end
							spc_pkg::OP_CLEAR_WRITE_LATCH: begin
								wel_d      = 1'b0;
								wel_pend_d = 1'b0;
							end
							spc_pkg::OP_ARRAY_WRITE: begin
								if (wel_q && !busy) begin
									state_d = spc_pkg::ST_ADDR;
									is_wr_d = 1'b1;
									mask_d  = 16'h0000;
								end
							end
							spc_pkg::OP_ARRAY_READ: begin
								state_d = spc_pkg::ST_ADDR;
								is_wr_d = 1'b0;
							end
							spc_pkg::OP_LOCK_STATUS_READ: begin
								state_d = spc_pkg::ST_LSTAT;
								so_d    = lock_byte[7] | busy;
								txsr_d  = {lock_byte[6:0], 1'b0};
							end
							spc_pkg::OP_CONFIG_WRITE: begin
								state_d = spc_pkg::ST_CFG;
							end
							spc_pkg::OP_CONTROL_WRITE: begin
								state_d = spc_pkg::ST_CTL;
							end
							spc_pkg::OP_STATUS_READ: begin
								state_d = spc_pkg::ST_SSTAT;
								so_d    = stat_byte[7];
								txsr_d  = {stat_byte[6:0], 1'b0};
							end
							spc_pkg::OP_PARTITION_LOCK: begin
								if (wel_q && !busy) begin
									state_d = spc_pkg::ST_LOCK;
								end
							end
							default: begin
								state_d = spc_pkg::ST_IGNORE;
							end
						endcase
					end
				end
				spc_pkg::ST_ADDR: begin
					if (byte_done) begin
						byteidx_d = 1'b1;
						if (!byteidx_q) begin
							addr_d[8] = sh_n[spc_pkg::ADDR_HI_BIT];
						end else if (is_wr_q) begin
							addr_d[7:0] = sh_n;
							state_d     = spc_pkg::ST_WDATA;
						end else begin
							state_d = spc_pkg::ST_RDATA;
							so_d    = rd_byte[7];
							txsr_d  = {rd_byte[6:0], 1'b0};
							addr_d  = rd_addr + 9'h001;
						end
					end
				end
				spc_pkg::ST_WDATA: begin
					if (byte_done) begin
						buf_we     = 1'b1;
						mask_d[addr_q[3:0]] = 1'b1;
						addr_d[3:0] = addr_q[3:0] + 4'h1;
						has_data_d = 1'b1;
					end
				end
				spc_pkg::ST_RDATA: begin
					if (byte_done) begin
						so_d   = rd_byte[7];
						txsr_d = {rd_byte[6:0], 1'b0};
						addr_d = addr_q + 9'h001;
					end
				end
				spc_pkg::ST_LSTAT: begin
					if (byte_done) begin
						so_d   = lock_byte[7];
						txsr_d = {lock_byte[6:0], 1'b0};
					end
				end
				spc_pkg::ST_SSTAT: begin
					if (byte_done) begin
						so_d   = stat_byte[7];
						txsr_d = {stat_byte[6:0], 1'b0};
					end
				end
				spc_pkg::ST_CFG, spc_pkg::ST_CTL: begin
					if (byte_done) begin
						byteidx_d = 1'b1;
						hold_d    = sh_n;
						if (byteidx_q) begin
							state_d = spc_pkg::ST_IGNORE;
							if (state_q == spc_pkg::ST_CFG) begin
								cfg_d = {hold_q, sh_n};
							end else begin
								ctl_d = {hold_q, sh_n};
							end
						end
					end
				end
				spc_pkg::ST_LOCK: begin
					if (byte_done) begin
						// Later bytes overwrite the earlier one
						hold_d     = sh_n;
						has_data_d = 1'b1;
					end
				end
				default: begin
				end
			endcase
			if (state_q == spc_pkg::ST_LSTAT && busy) begin
				so_d = 1'b1;
			end
		end
	end

	// Registered state; latch clear at reset
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_q    <= spc_pkg::ST_OPCODE;
			bitcnt_q   <= 3'h0;
			byteidx_q  <= 1'b0;
			shreg_q    <= 8'h00;
			txsr_q     <= 8'h00;
			so_q       <= 1'b0;
			oe_n_q     <= 1'b1;
			addr_q     <= 9'h000;
			is_wr_q    <= 1'b0;
			has_data_q <= 1'b0;
			hold_q     <= 8'h00;
			wel_q      <= 1'b0;
			wel_pend_q <= 1'b0;
			lock_q     <= spc_pkg::LOCK_RESET;
			cfg_q      <= spc_pkg::CFG_RESET;
			ctl_q      <= spc_pkg::CTL_RESET;
			busy_q     <= 24'h000000;
			mask_q     <= 16'h0000;
			cpage_q    <= 5'h00;
			flush_q    <= 1'b0;
			fidx_q     <= 4'h0;
		end else begin
			state_q    <= state_d;
			bitcnt_q   <= bitcnt_d;
			byteidx_q  <= byteidx_d;
			shreg_q    <= shreg_d;
			txsr_q     <= txsr_d;
			so_q       <= so_d;
			oe_n_q     <= oe_n_d;
			addr_q     <= addr_d;
			is_wr_q    <= is_wr_d;
			has_data_q <= has_data_d;
			hold_q     <= hold_d;
			wel_q      <= wel_d;
			wel_pend_q <= wel_pend_d;
			lock_q     <= lock_d;
			cfg_q      <= cfg_d;
			ctl_q      <= ctl_d;
			busy_q     <= busy_d;
			mask_q     <= mask_d;
			cpage_q    <= cpage_d;
			flush_q    <= flush_d;
			fidx_q     <= fidx_d;
		end
	end

	// Storage holds no reset; page buffer only lands on commit
	always_ff @(posedge mclk) begin
		if (buf_we) begin
			pbuf[addr_q[3:0]] <= sh_n;
		end
		if (flush_q && mask_q[fidx_q]) begin
			mem[{cpage_q, fidx_q}] <= pbuf[fidx_q];
		end
	end

	assign spi_so           = so_q;
	assign spi_so_oe_n      = oe_n_q;
	assign cfg_reg          = cfg_q;
	assign ctl_reg          = ctl_q;
	assign lock_select_bits = lock_q;
	assign write_latch      = wel_q;
	assign write_busy       = busy;
endmodule

// [spc_pkg.sv]
// Shared constants and types for the serial command port
package spc_pkg;

	// Opcodes, most significant bit first on the wire
	localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
	localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
	localparam logic [7:0] OP_ARRAY_WRITE       = 8'h02;
	localparam logic [7:0] OP_ARRAY_READ        = 8'h03;
	localparam logic [7:0] OP_LOCK_STATUS_READ  = 8'h05;
	localparam logic [7:0] OP_CONFIG_WRITE      = 8'h09;
	localparam logic [7:0] OP_CONTROL_WRITE     = 8'h0a;
	localparam logic [7:0] OP_STATUS_READ       = 8'h0b;
	localparam logic [7:0] OP_PARTITION_LOCK    = 8'h01;

	// Array geometry
	localparam int ADDR_W     = 9;
	localparam int MEM_DEPTH  = 512;
	localparam int PAGE_BYTES = 16;
	localparam int COL_W      = 4;
	localparam int PAGE_W     = 5;

	// Field widths and positions
	localparam int LOCK_W     = 3;
	localparam int STATUS_W   = 3;
	localparam int REG_W      = 16;
	localparam int ADDR_HI_BIT = 0;

	// Reset values
	localparam logic [15:0] CFG_RESET  = 16'h0000;
	localparam logic [15:0] CTL_RESET  = 16'h0000;
	localparam logic [2:0]  LOCK_RESET = 3'h0;

	// Timing: nonvolatile write cycle
	localparam int CLK_MHZ  = 50;
	localparam int TWC_US   = 5;
	localparam int TWC_CYC  = TWC_US * CLK_MHZ;

	// Link pins after synchronisation
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
	} spc_pins_t;

	// Frame decoder states
	typedef enum logic [3:0] {
		ST_OPCODE,
		ST_ADDR,
		ST_WDATA,
		ST_RDATA,
		ST_LSTAT,
		ST_CFG,
		ST_CTL,
		ST_LOCK,
		ST_SSTAT,
		ST_IGNORE
	} spc_state_t;

endpackage

// [spc_sync.sv]
// Two-flop synchroniser for pins entering the mclk domain
`timescale 1ns/10ps
module spc_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	// First flop feeds only the second one
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// [spc_port_props.sv]
// Checker for the serial command port pins and register outputs
`timescale 1ns/10ps
module spc_port_props #(
	parameter int unsigned NV_WRITE_CYCLES = 250
) (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        spi_cs_n,
	input wire logic        spi_sck,
	input wire logic        spi_si,
	input wire logic        spi_so,
	input wire logic        spi_so_oe_n,
	input wire logic [2:0]  status_bits,
	input wire logic [15:0] cfg_reg,
	input wire logic [15:0] ctl_reg,
	input wire logic [2:0]  lock_select_bits,
	input wire logic        write_latch,
	input wire logic        write_busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	logic [15:0] bcnt_q, bcnt_d;
	logic [3:0]  age_q, age_d;
	logic        sck_q, sck_d;

	// Busy length and cycles since the last raw clock rise
	always_comb begin
		bcnt_d = write_busy ? bcnt_q + 16'h0001 : 16'h0000;
		age_d = (age_q == 4'hf) ? age_q : age_q + 4'h1;
		if (spi_sck && !sck_q)
			age_d = 4'h0;
		sck_d = spi_sck;
	end

	// Saturating age keeps idle stretches from wrapping
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			bcnt_q <= 16'h0000;
			age_q  <= 4'hf;
			sck_q  <= 1'b0;
		end else begin
			bcnt_q <= bcnt_d;
			age_q  <= age_d;
			sck_q  <= sck_d;
		end
	end

	sequence s_desel;
		spi_cs_n [*6];
	endsequence
	sequence s_sel;
		(!spi_cs_n) [*6];
	endsequence

	AST_OE_RELEASE: assert property (s_desel |-> spi_so_oe_n)
		else $error("output enable active while deselected");
	AST_SO_IDLE: assert property (s_desel |-> !spi_so)
		else $error("serial out not quiet while deselected");
	AST_OE_DRIVE: assert property (s_sel |-> !spi_so_oe_n)
		else $error("output enable off while selected");
	AST_SO_ON_RISE: assert property ($changed(spi_so) && !spi_cs_n
		&& !$past(spi_cs_n, 6) |-> age_q <= 4'h4)
		else $error("serial out moved away from a clock rise");
	AST_BUSY_LEN: assert property ($fell(write_busy)
		|-> bcnt_q == NV_WRITE_CYCLES)
		else $error("write cycle length wrong");
	AST_WRITE_NEEDS_LATCH: assert property ($rose(write_busy)
		|-> $past(write_latch))
		else $error("write started without latch");
	AST_COMMIT_ON_DESELECT: assert property ($rose(write_busy)
		|-> $past(spi_cs_n, 2))
		else $error("write started while selected");
	AST_LATCH_DROP: assert property ($rose(write_busy)
		|-> ##[0:2] !write_latch)
		else $error("latch not cleared by write");
	AST_LATCH_AT_FRAME_END: assert property ($rose(write_latch)
		|-> $past(spi_cs_n, 2))
		else $error("latch set inside a frame");
	AST_REGS_HOLD: assert property (s_desel
		|=> $stable(cfg_reg) && $stable(ctl_reg))
		else $error("register changed while deselected");
endmodule

bind spc_port spc_port_props #(
	.NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) spc_port_props_inst (
	.mclk            (mclk),
	.rstn            (rstn),
	.spi_cs_n        (spi_cs_n),
	.spi_sck         (spi_sck),
	.spi_si          (spi_si),
	.spi_so          (spi_so),
	.spi_so_oe_n     (spi_so_oe_n),
	.status_bits     (status_bits),
	.cfg_reg         (cfg_reg),
	.ctl_reg         (ctl_reg),
	.lock_select_bits(lock_select_bits),
	.write_latch     (write_latch),
	.write_busy      (write_busy)
);

// [spc_host.sv]
// Host bus master model driving the serial command port
`timescale 1ns/10ps
module spc_host (
	input  wire logic mclk,
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so
);
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	// Step n cycles, then move just past the edge
	task automatic tk(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic sel(input logic lvl);
		tk(8);
		cs_n = lvl;
		// Released data line flips so a stale level cannot pass
		if (lvl)
			si = ~si;
		tk(8);
	endtask

	task automatic xfer(input logic [7:0] d, input int n,
		output logic [7:0] r);
		r = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			si = d[i];
			tk(4);
			r[i] = so;
			sck = 1'b1;
			tk(4);
			sck = 1'b0;
		end
	endtask
endmodule

// [spc_port_tb_top.sv]
// Self-checking bench for the serial command port
`timescale 1ns/10ps
module spc_port_tb_top;
	typedef struct {
		logic [7:0]  op;
		int          nb;
		logic [15:0] d;
		logic [15:0] cfg;
		logic [15:0] ctl;
		logic        lat;
	} spc_row_t;

	logic        mclk, rstn, cs_n, sck, si, so, oe_n, latch, busy;
	logic [2:0]  st, lock;
	logic [15:0] cfg, ctl;
	logic [7:0]  b;
	logic [15:0] rx [$];
	int          num_errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	spc_row_t    rows [6] = '{
		'{8'h06, 0, 16'h0000, 16'h0000, 16'h0000, 1'b1},
		'{8'h04, 0, 16'h0000, 16'h0000, 16'h0000, 1'b0},
		'{8'h09, 2, 16'ha53c, 16'ha53c, 16'h0000, 1'b0},
		'{8'h0a, 2, 16'h5ac3, 16'ha53c, 16'h5ac3, 1'b0},
		'{8'h09, 2, 16'hff00, 16'hff00, 16'h5ac3, 1'b0},
		'{8'h06, 0, 16'h0000, 16'hff00, 16'h5ac3, 1'b1}};

	spc_port #(.NV_WRITE_CYCLES(200)) spc_port_inst (
		.mclk(mclk), .rstn(rstn), .spi_cs_n(cs_n), .spi_sck(sck),
		.spi_si(si), .spi_so(so), .spi_so_oe_n(oe_n),
		.status_bits(st), .cfg_reg(cfg), .ctl_reg(ctl),
		.lock_select_bits(lock), .write_latch(latch),
		.write_busy(busy));
	// Released output shows the inverse of its last level
	spc_host spc_host_inst (
		.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si),
		.so(oe_n ? ~so : so));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One whole frame; received bytes land in rx
	task automatic frame(input logic [7:0] q [$]);
		logic [7:0] r;
		rx.delete();
		spc_host_inst.sel(1'b0);
		foreach (q[i]) begin
			spc_host_inst.xfer(q[i], 8, r);
			rx.push_back({8'h00, r});
		end
		spc_host_inst.sel(1'b1);
	endtask

	// Bounded wait for the write cycle to end
	task automatic wait_idle();
		spc_host_inst.tk(4);
		for (int k = 0; k < 300 && busy !== 1'b0; k++)
			spc_host_inst.tk(1);
		chk({15'h0, busy}, 16'h0000);
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Hang guard, far above the expected run length
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			results();
		end
	end

	initial begin
		rstn = 1'b0;
		st = 3'h5;
		spc_host_inst.tk(3);
		chk(cfg | ctl, 16'h0000);
		chk({9'h0, lock, latch, busy, oe_n, so}, 16'h0002);
		rstn = 1'b1;
		spc_host_inst.tk(4);
		foreach (rows[i]) begin
			if (rows[i].nb == 2)
				frame('{rows[i].op, rows[i].d[15:8], rows[i].d[7:0]});
			else
				frame('{rows[i].op});
			chk(cfg, rows[i].cfg);
			chk(ctl, rows[i].ctl);
			chk({15'h0, latch}, {15'h0, rows[i].lat});
		end
		frame('{8'h0b, 8'h00, 8'h00});
		chk(rx[1] & rx[2], 16'h0005);
		frame('{8'h02, 8'h00, 8'h00, 8'h5c});
		chk({14'h0, busy, latch}, 16'h0002);
		wait_idle();
		frame('{8'h06});
		frame('{8'h02, 8'h01, 8'hfe, 8'ha0, 8'ha1, 8'ha2});
		frame('{8'h05, 8'h00});
		chk(rx[1], 16'h00ff);
		wait_idle();
		frame('{8'h05, 8'h00});
		chk(rx[1], 16'h0000);
		frame('{8'h03, 8'h01, 8'hfe, 8'h00, 8'h00, 8'h00});
		chk({rx[3][7:0], rx[4][7:0]}, 16'ha0a1);
		chk(rx[5], 16'h005c);
		frame('{8'h03, 8'h01, 8'hf0, 8'h00});
		chk(rx[3], 16'h00a2);
		frame('{8'h02, 8'h00, 8'h00, 8'h77});
		chk({15'h0, busy}, 16'h0000);
		frame('{8'h06, 8'h02, 8'h00, 8'h00, 8'h77});
		chk({14'h0, busy, latch}, 16'h0001);
		spc_host_inst.sel(1'b0);
		spc_host_inst.xfer(8'h02, 8, b);
		spc_host_inst.xfer(8'h00, 8, b);
		spc_host_inst.xfer(8'h00, 8, b);
		spc_host_inst.xfer(8'h77, 8, b);
		spc_host_inst.xfer(8'h00, 4, b);
		spc_host_inst.sel(1'b1);
		chk({14'h0, busy, latch}, 16'h0001);
		frame('{8'h03, 8'h00, 8'h00, 8'h00});
		chk(rx[3], 16'h005c);
		frame('{8'h01, 8'h06});
		wait_idle();
		chk({13'h0, lock}, 16'h0006);
		frame('{8'h05, 8'h00});
		chk(rx[1], 16'h0006);
		frame('{8'h06});
		frame('{8'h02, 8'h00, 8'h00, 8'h88});
		wait_idle();
		frame('{8'h03, 8'h00, 8'h00, 8'h00});
		chk(rx[3], 16'h005c);
		// Long pauses between bytes must not lose the frame
		spc_host_inst.sel(1'b0);
		spc_host_inst.xfer(8'h0a, 8, b);
		spc_host_inst.tk(40);
		spc_host_inst.xfer(8'h12, 8, b);
		spc_host_inst.tk(40);
		spc_host_inst.xfer(8'h34, 8, b);
		spc_host_inst.sel(1'b1);
		chk(ctl, 16'h1234);
		// Second reset mid-run; latch is set here so its clear shows
		rstn = 1'b0;
		spc_host_inst.tk(3);
		chk(cfg | ctl, 16'h0000);
		chk({12'h0, lock, latch}, 16'h0000);
		rstn = 1'b1;
		st = 3'h2;
		spc_host_inst.tk(4);
		frame('{8'h0b, 8'h00});
		chk(rx[1], 16'h0002);
		results();
	end
endmodule
